// ===== shared/pdio_pkg.sv
// Constants and types of the parallel digital I/O port block.
// Assumes an APB master on pclk and static jumper and switch pins.
package pdio_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register indices inside the 16-byte window; byte addr = 4 * index
    localparam logic [1:0] IDX_PORT_A = 2'h0;
    localparam logic [1:0] IDX_PORT_B = 2'h1;
    localparam logic [1:0] IDX_PORT_C = 2'h2;
    localparam logic [1:0] IDX_CONFIG = 2'h3;
    // Local registers, outside the emulated host window
    localparam logic [1:0] IDX_IRQ_STATUS = 2'h0;
    localparam logic [1:0] IDX_IRQ_MASK = 2'h1;
    localparam logic [1:0] IDX_STRAPS = 2'h2;

    // Address fields of paddr
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 3;
    localparam int BASE_LSB = 4;
    localparam int BASE_MSB = 11;
    localparam int LOCAL_BIT = 12;
    localparam int TOP_ZERO_LSB = 13;

    ////////////////////////////////////////////////////////////////////
    // Configuration word: one input flag per group, mode in high nibble
    localparam int CFG_A_IN = 0;
    localparam int CFG_B_IN = 1;
    localparam int CFG_CLO_IN = 2;
    localparam int CFG_CHI_IN = 3;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_MODE_MSB = 7;
    localparam logic [3:0] MODE_BASIC = 4'h0;
    localparam logic [7:0] CFG_RESET = 8'h0F;

    ////////////////////////////////////////////////////////////////////
    // Interrupt sources and gate line (indices into the 24 lines)
    localparam int IRQ_SRC0 = 16;
    localparam int IRQ_SRC1 = 19;
    localparam int IRQ_GATE = 23;
    localparam logic [1:0] IEN_OFF = 2'h0;
    localparam logic [1:0] IEN_PROG = 2'h1;
    localparam logic [1:0] IEN_ON = 2'h2;
    localparam logic [2:0] IRQ_LVL_MIN = 3'h2;
    localparam logic [2:0] IRQ_LVL_MAX = 3'h7;
    localparam int NUM_LVL = 6;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_READY
    } pdio_bus_e;

    typedef struct packed {
        logic wait_en;
        logic [2:0] level;
        logic [1:0] ien;
    } pdio_jmp_s;

endpackage

// ===== logic/pdio_top.sv
// Parallel digital I/O port block: 24 lines, APB register access,
// jumper-selected interrupt forwarding and optional bus wait state.
// Assumes pins, DIP switches and jumpers are asynchronous to pclk.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
module pdio_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [23:0] line_in,
    output logic [23:0] line_out,
    output logic [23:0] line_oe,
    input wire logic [7:0] base_switch,
    input wire logic wait_jumper,
    input wire logic [2:0] irq_level_jumper,
    input wire logic [1:0] irq_enable_jumper,
    output logic [pdio_pkg::NUM_LVL-1:0] host_irq,
    output logic irq
);
    localparam int NUM_LVL_O = pdio_pkg::NUM_LVL;

    typedef struct packed {
        pdio_pkg::pdio_bus_e st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [23:0] pin_m;
        logic [23:0] pin_s;
        logic [7:0] sw_m;
        logic [7:0] sw_s;
        pdio_pkg::pdio_jmp_s jmp_m;
        pdio_pkg::pdio_jmp_s jmp_s;
        logic [1:0] ev_prev;
        logic [1:0] status;
        logic [1:0] mask;
        logic [7:0] cfg;
        logic [23:0] latch;
        logic [23:0] oe;
        logic [NUM_LVL_O-1:0] host_irq;
        logic irq;
    } pdio_state_s;

    pdio_state_s s_q;
    pdio_state_s s_d;

    ////////////////////////////////////////////////////////////////////
    // Output enables per line from the configuration word
    function automatic logic [23:0] pdio_oe_of(input logic [7:0] cfg);
        pdio_oe_of = {{4{~cfg[pdio_pkg::CFG_CHI_IN]}},
                      {4{~cfg[pdio_pkg::CFG_CLO_IN]}},
                      {8{~cfg[pdio_pkg::CFG_B_IN]}},
                      {8{~cfg[pdio_pkg::CFG_A_IN]}}};
    endfunction

    // Window hit: top bits zero, base bits match switches, not local
    function automatic logic pdio_in_window(input logic [31:0] a,
                                            input logic [7:0] sw);
        pdio_in_window = (a[31:pdio_pkg::TOP_ZERO_LSB] == '0) &&
                         !a[pdio_pkg::LOCAL_BIT] &&
                         (a[pdio_pkg::BASE_MSB:pdio_pkg::BASE_LSB] == sw);
    endfunction

    function automatic logic pdio_is_local(input logic [31:0] a);
        pdio_is_local = (a[31:pdio_pkg::TOP_ZERO_LSB] == '0) &&
                        a[pdio_pkg::LOCAL_BIT] &&
                        (a[pdio_pkg::BASE_MSB:pdio_pkg::BASE_LSB] == '0);
    endfunction

    logic setup_c;
    logic done_c;
    logic hit_c;
    logic loc_c;
    logic [1:0] idx_c;
    logic [1:0] ev_now_c;
    logic [1:0] rise_c;
    logic gate_c;
    logic req_c;
    logic [2:0] lvl_c;

    assign setup_c = psel && !penable;
    assign done_c = psel && penable && s_q.pready;
    assign hit_c = pdio_in_window(paddr, s_q.sw_s);
    assign loc_c = pdio_is_local(paddr);
    assign idx_c = paddr[pdio_pkg::IDX_MSB:pdio_pkg::IDX_LSB];
    assign ev_now_c = {s_q.pin_s[pdio_pkg::IRQ_SRC1],
                       s_q.pin_s[pdio_pkg::IRQ_SRC0]};
    assign rise_c = ev_now_c & ~s_q.ev_prev;
    assign lvl_c = s_q.jmp_s.level;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        gate_c = 1'b0;
        req_c = 1'b0;
        // Pin, switch and jumper synchronisers
        s_d.pin_m = line_in;
        s_d.pin_s = s_q.pin_m;
        s_d.sw_m = base_switch;
        s_d.sw_s = s_q.sw_m;
        s_d.jmp_m = '{wait_en: wait_jumper, level: irq_level_jumper,
                      ien: irq_enable_jumper};
        s_d.jmp_s = s_q.jmp_m;

        // Bus phase machine; pready is a flop so the fastest answer
        // is one cycle after the setup edge
        case (s_q.st)
            pdio_pkg::ST_IDLE: begin
                s_d.pready = 1'b0;
                if (setup_c) begin
                    if (s_q.jmp_s.wait_en && hit_c) begin
                        s_d.st = pdio_pkg::ST_WAIT;
                    end else begin
                        s_d.st = pdio_pkg::ST_READY;
                        s_d.pready = 1'b1;
                    end
                end
            end
            pdio_pkg::ST_WAIT: begin
                s_d.st = pdio_pkg::ST_READY;
                s_d.pready = 1'b1;
            end
            default: begin
                if (done_c) begin
                    s_d.st = pdio_pkg::ST_IDLE;
                    s_d.pready = 1'b0;
                end
            end
        endcase

        // Read data and error prepared while the answer is built
        if (s_d.pready && !done_c) begin
            s_d.prdata = '0;
            s_d.pslverr = 1'b0;
            if (hit_c) begin
                if (idx_c == pdio_pkg::IDX_PORT_A) begin
                    s_d.prdata[7:0] = s_q.pin_s[7:0];
                end else if (idx_c == pdio_pkg::IDX_PORT_B) begin
                    s_d.prdata[7:0] = s_q.pin_s[15:8];
                end else if (idx_c == pdio_pkg::IDX_PORT_C) begin
                    s_d.prdata[7:0] = s_q.pin_s[23:16];
                end else if (pwrite && pwdata[pdio_pkg::CFG_MODE_MSB:
                             pdio_pkg::CFG_MODE_LSB] !=
                             pdio_pkg::MODE_BASIC) begin
                    s_d.pslverr = 1'b1;
                end else begin
                    s_d.prdata = '0;
                end
            end else if (loc_c) begin
                if (idx_c == pdio_pkg::IDX_IRQ_STATUS) begin
                    s_d.prdata[1:0] = s_q.status;
                end else if (idx_c == pdio_pkg::IDX_IRQ_MASK) begin
                    s_d.prdata[1:0] = s_q.mask;
                end else if (idx_c == pdio_pkg::IDX_STRAPS) begin
                    s_d.prdata[13:0] = {s_q.jmp_s, s_q.sw_s};
                end else begin
                    s_d.pslverr = 1'b1;
                end
            end else begin
                s_d.pslverr = 1'b1;
            end
        end

        // Writes act only at the completing edge and without error
        if (done_c && pwrite && !s_q.pslverr) begin
            if (hit_c) begin
                if (idx_c == pdio_pkg::IDX_PORT_A) begin
                    s_d.latch[7:0] = pwdata[7:0];
                end else if (idx_c == pdio_pkg::IDX_PORT_B) begin
                    s_d.latch[15:8] = pwdata[7:0];
                end else if (idx_c == pdio_pkg::IDX_PORT_C) begin
                    s_d.latch[23:16] = pwdata[7:0];
                end else begin
                    // New direction clears latches, so no stale drive
                    s_d.cfg = pwdata[7:0];
                    s_d.latch = '0;
                end
            end else if (loc_c) begin
                if (idx_c == pdio_pkg::IDX_IRQ_MASK) begin
                    s_d.mask = pwdata[1:0];
                end
            end
        end
        s_d.oe = pdio_oe_of(s_d.cfg);

        // Sticky events; a new edge wins over a clear
        s_d.ev_prev = ev_now_c;
        if (done_c && pwrite && loc_c &&
            idx_c == pdio_pkg::IDX_IRQ_STATUS) begin
            s_d.status = s_q.status & ~pwdata[1:0];
        end
        s_d.status = s_d.status | rise_c;

        if (s_q.jmp_s.ien == pdio_pkg::IEN_ON) begin
            gate_c = 1'b1;
        end else if (s_q.jmp_s.ien == pdio_pkg::IEN_PROG) begin
            gate_c = s_q.pin_s[pdio_pkg::IRQ_GATE];
        end
        req_c = gate_c && |(s_q.status & s_q.mask);
        s_d.irq = req_c;
        s_d.host_irq = '0;
        for (int i = 0; i < NUM_LVL_O; i++) begin
            if (req_c && lvl_c >= pdio_pkg::IRQ_LVL_MIN &&
                lvl_c - pdio_pkg::IRQ_LVL_MIN == 3'(i)) begin
                s_d.host_irq[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= pdio_pkg::ST_IDLE;
            s_q.cfg <= pdio_pkg::CFG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign line_out = s_q.latch;
    assign line_oe = s_q.oe;
    assign host_irq = s_q.host_irq;
    assign irq = s_q.irq;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_oe_from_cfg: assert property (
        s_q.oe == pdio_oe_of(s_q.cfg))
        else $error("line enables disagree with configuration");
    a_c_halves: assert property (
        line_oe[19:16] == {4{line_oe[16]}} &&
        line_oe[23:20] == {4{line_oe[20]}})
        else $error("port C half not uniform");
    a_reset_inputs: assert property (
        $rose(presetn) |-> line_oe == '0)
        else $error("line driven right after reset");
    a_mode_refused: assert property (
        done_c && pwrite && hit_c && idx_c == pdio_pkg::IDX_CONFIG &&
        pslverr |=> $stable(s_q.cfg))
        else $error("non-basic mode accepted");
    a_event_sticky: assert property (
        rise_c[0] |=> s_q.status[0])
        else $error("event edge lost");
    a_irq_off: assert property (
        s_q.jmp_s.ien == pdio_pkg::IEN_OFF |=> !irq)
        else $error("interrupt passed while blocked");
    a_one_level: assert property (
        $onehot0(host_irq) && (irq || host_irq == '0))
        else $error("more than one level driven");
    a_wait_state: assert property (
        setup_c && hit_c && s_q.jmp_s.wait_en && s_q.st == pdio_pkg::ST_IDLE
        |=> !pready ##1 pready)
        else $error("wait state not inserted");
    a_no_wait: assert property (
        setup_c && !s_q.jmp_s.wait_en && s_q.st == pdio_pkg::ST_IDLE
        |=> pready)
        else $error("answer late without wait jumper");
    a_outside_ignored: assert property (
        done_c && !hit_c && !loc_c |=> $stable(s_q.latch) &&
        $stable(s_q.cfg))
        else $error("access outside window took effect");
    a_port_latch: assert property (
        done_c && pwrite && hit_c && idx_c == pdio_pkg::IDX_PORT_A
        |=> line_out[7:0] == $past(pwdata[7:0]))
        else $error("port A latch not updated");

    c_wait_access: cover property (
        setup_c && s_q.jmp_s.wait_en && hit_c ##2 done_c);
    c_cfg_write: cover property (
        done_c && pwrite && hit_c && idx_c == pdio_pkg::IDX_CONFIG);
    c_irq_raised: cover property ($rose(irq));
    c_split_c: cover property (line_oe[16] != line_oe[20]);
endmodule

// ===== verif/pdio_host.sv
// Host processor model: an APB master driven by the bench through xfer.
// Assumes the block answers with pready; the bench owns the timeout.
module pdio_host (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
    end

    // One transfer; waits counts access-phase edges up to completion
    task automatic xfer(input logic wr, input logic [31:0] addr,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err, output int waits);
        waits = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            waits++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus must not keep showing the old request
        paddr <= ~addr;
        pwdata <= ~wd;
    endtask
endmodule

// ===== verif/pdio_top_tb.sv
// Self-checking bench of the parallel digital I/O port block.
// Assumes pdio_host as bus master; field pins are modelled here.
module pdio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
        logic [7:0] rd;
        logic err;
        logic [23:0] oe;
        logic [23:0] out;
    } pdio_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [23:0] line_in, line_out, line_oe;
    logic [23:0] ext = 24'h00_C369;
    logic [7:0] base_switch = 8'h2D;
    logic wait_jumper = 1'b0;
    logic [2:0] irq_level_jumper = 3'h2;
    logic [1:0] irq_enable_jumper = pdio_pkg::IEN_ON;
    logic [pdio_pkg::NUM_LVL-1:0] host_irq;
    int waits;
    int err_count = 0;
    int n_tests = 0;
    pdio_row_s rows [14] = '{
        '{1'b1, 16'h02DC, 8'h00, 8'h00, 1'b0, 24'hFF_FFFF, 24'h00_0000},
        '{1'b1, 16'h02D0, 8'hA5, 8'h00, 1'b0, 24'hFF_FFFF, 24'h00_00A5},
        '{1'b1, 16'h02D4, 8'h3C, 8'h00, 1'b0, 24'hFF_FFFF, 24'h00_3CA5},
        '{1'b1, 16'h02D8, 8'h5A, 8'h00, 1'b0, 24'hFF_FFFF, 24'h5A_3CA5},
        '{1'b0, 16'h02D0, 8'h00, 8'hA5, 1'b0, 24'hFF_FFFF, 24'h5A_3CA5},
        '{1'b0, 16'h02DC, 8'h00, 8'h00, 1'b0, 24'hFF_FFFF, 24'h5A_3CA5},
        '{1'b1, 16'h02DC, 8'h10, 8'h00, 1'b1, 24'hFF_FFFF, 24'h5A_3CA5},
        '{1'b0, 16'h02D8, 8'h00, 8'h5A, 1'b0, 24'hFF_FFFF, 24'h5A_3CA5},
        '{1'b1, 16'h02DC, 8'h05, 8'h00, 1'b0, 24'hF0_FF00, 24'h00_0000},
        '{1'b0, 16'h02D0, 8'h00, 8'h69, 1'b0, 24'hF0_FF00, 24'h00_0000},
        '{1'b0, 16'h02D4, 8'h00, 8'h00, 1'b0, 24'hF0_FF00, 24'h00_0000},
        '{1'b1, 16'h03D0, 8'h77, 8'h00, 1'b1, 24'hF0_FF00, 24'h00_0000},
        '{1'b1, 16'h22D0, 8'h77, 8'h00, 1'b1, 24'hF0_FF00, 24'h00_0000},
        '{1'b1, 16'h02DC, 8'h0F, 8'h00, 1'b0, 24'h00_0000, 24'h00_0000}
    };

    // Driven lines read back their latch, released lines the field
    assign line_in = (line_out & line_oe) | (ext & ~line_oe);
    always #25 pclk = ~pclk;

    pdio_host host (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    pdio_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .base_switch(base_switch),
        .wait_jumper(wait_jumper), .irq_level_jumper(irq_level_jumper),
        .irq_enable_jumper(irq_enable_jumper), .host_irq(host_irq),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic acc(input logic wr, input logic [31:0] a,
            input logic [31:0] d);
        host.xfer(wr, a, d, rd, err, waits);
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        tick(12);
        check("oe", line_oe, 32'h0000_0000);
        check("out", line_out, 32'h0000_0000);
        check("irq", {host_irq, irq}, 32'h0000_0000);
        presetn <= 1'b1;
        // Switch and jumper synchronisers need two edges
        tick(3);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(20000);
        err_count++;
        stop_test();
    end

    initial begin
        do_reset();
        foreach (rows[i]) begin
            acc(rows[i].wr, {16'h0000, rows[i].addr}, {24'h0, rows[i].data});
            tick(2);
            check("err", err, rows[i].err);
            check("waits", waits, 1);
            if (!rows[i].wr) begin
                check("rdata", rd, {24'h0, rows[i].rd});
            end
            check("oe", line_oe, rows[i].oe);
            check("out", line_out, rows[i].out);
        end
        wait_jumper <= 1'b1;
        tick(3);
        acc(1'b0, 32'h0000_02D0, 32'h0000_0000);
        check("waits", waits, 2);
        acc(1'b0, 32'h0000_0100, 32'h0000_0000);
        check("waits", waits, 1);
        wait_jumper <= 1'b0;
        base_switch <= 8'h3F;
        tick(3);
        acc(1'b0, 32'h0000_03F0, 32'h0000_0000);
        check("rdata", {err, rd[30:0]}, 32'h0000_0069);
        acc(1'b0, 32'h0000_02D0, 32'h0000_0000);
        check("err", err, 1);
        acc(1'b0, 32'h0000_100C, 32'h0000_0000);
        check("err", err, 1);
        acc(1'b0, 32'h0000_1008, 32'h0000_0000);
        check("straps", rd, 32'h0000_0A3F);
        // Line 19 rose while port C drove 5A in the rows
        acc(1'b0, 32'h0000_1000, 32'h0000_0000);
        check("status", rd, 32'h0000_0002);
        acc(1'b1, 32'h0000_1000, 32'h0000_0003);
        acc(1'b1, 32'h0000_1004, 32'h0000_0003);
        ext[16] <= 1'b1;
        tick(6);
        check("irq", irq, 1);
        for (int l = 2; l <= 7; l++) begin
            irq_level_jumper <= 3'(l);
            tick(5);
            check("host_irq", host_irq, 32'(1) << (l - 2));
        end
        // Levels below 2 drive no host line
        irq_level_jumper <= 3'h1;
        tick(5);
        check("host_irq", host_irq, 32'h0000_0000);
        irq_enable_jumper <= 2'h3;
        tick(5);
        check("irq", irq, 0);
        irq_enable_jumper <= pdio_pkg::IEN_OFF;
        tick(5);
        check("irq", {host_irq, irq}, 32'h0000_0000);
        irq_enable_jumper <= pdio_pkg::IEN_PROG;
        tick(5);
        check("irq", irq, 0);
        ext[23] <= 1'b1;
        tick(5);
        check("irq", irq, 1);
        acc(1'b1, 32'h0000_1004, 32'h0000_0002);
        tick(3);
        check("irq", irq, 0);
        ext[19] <= 1'b1;
        tick(6);
        check("irq", irq, 1);
        acc(1'b0, 32'h0000_1000, 32'h0000_0000);
        check("status", rd, 32'h0000_0003);
        acc(1'b1, 32'h0000_1000, 32'h0000_0002);
        tick(3);
        check("irq", irq, 0);
        acc(1'b0, 32'h0000_1000, 32'h0000_0000);
        check("status", rd, 32'h0000_0001);
        // Reset in mid-run with every line driving
        acc(1'b1, 32'h0000_03FC, 32'h0000_0000);
        tick(2);
        check("oe", line_oe, 32'h00FF_FFFF);
        do_reset();
        stop_test();
    end
endmodule
